// ==== csp_serial_port.sv ====
`timescale 1ns/1ps
// Behaviour
// - halt mode: no shift, plain 8-bit register
// - reset gives halt, data pins input only
// - clock pin can be plain input
// - three-wire moves eight-bit blocks on clock
// - shift on fall, sample on rise
// - after eight bits stop, set interrupt
// - three-wire output push-pull from output latch
// - internal clock pin follows port latch
// - lsb-first reverses register reads and writes
// - two-wire sends msb first on data pin; code still sends lsb first there when lsb_first is set
// - two-wire data pin is open-drain, pulls low
// - two-wire pin shows latch, triggers set it
// - bus bytes classed address, command or data
// - master selects slave by sending address
// - wake-up interrupts only on address match
// - wake-up switchable by software anytime
// - software controls acknowledge generation
// - software controls busy indication
// - bus data pin open-drain, wired line
// - start only on write, enabled, clock high
// - interrupt on ninth rise, or matched address
// - acknowledge is one low clock after byte
// - release rising, command falling, clock high
module csp_serial_port
    import csp_pkg::*;
#(
    parameter int SCLK_HALF = CSP_SCLK_HALF_CYC
) (
    input wire logic clk_sys,              // system clock
    input wire logic srst,                 // sync reset, active high
    input wire logic sclk_link,            // serial clock line as a clock
    input wire csp_cfg_t cfg,              // configuration levels
    input wire csp_trig_t trig,            // cpu strobes
    input wire logic [7:0] wr_data,        // data for a write strobe
    input wire logic clock_pin_port_latch, // static level for clock pin
    output csp_stat_t stat,                // status to cpu
    input wire logic sclk_i,               // clock pin level
    output logic sclk_o,                   // clock pin drive value
    output logic sclk_oe,                  // clock pin drive enable
    input wire logic pa_i,                 // bus_data_pin_a level
    output logic pa_o,                     // pin a drive value
    output logic pa_oe,                    // pin a drive enable
    input wire logic pb_i,                 // bus_data_pin_b level
    output logic pb_o,                     // pin b drive value
    output logic pb_oe                     // pin b drive enable
);

    csp_sys_t s, next_s;     // system side
    csp_lnk_t l, next_l;     // link rising edge side
    csp_neg_t g, next_g;     // link falling edge side

    logic bus_mode;          // serial bus mode selected
    logic od_mode;           // two-wire or bus: shared open-drain line
    logic line_raw;          // selected data line level
    logic link_on;           // link has taken over the output bit
    logic dval;              // data bit level before pin driver
    logic pull_low;          // open-drain pull
    logic done_ev;           // transfer finished, system side
    logic addr_match;        // received byte is our address
    logic can_start;         // start conditions met
    logic [4:0] gen_total;   // clock edges to make per transfer

    assign bus_mode = (cfg.mode == CSP_SERIAL_BUS);
    assign od_mode = (cfg.mode == CSP_TWO_WIRE) || bus_mode;
    // three-wire input always sits on pin b
    assign line_raw = (cfg.data_on_pin_b || !od_mode) ? pb_i : pa_i;
    assign done_ev = s.done_s2 ^ s.done_d;
    assign addr_match = (l.shreg == cfg.slave_address_register);
    assign gen_total = bus_mode ? {CSP_BUS_CLOCKS, 1'b0} : {CSP_BITS, 1'b0};
    assign can_start = cfg.serial_channel_enable && cfg.mode != CSP_HALT &&
        s.sck_s2;

    // ---------------- system clock domain ----------------

    // cpu access, start, flags, clock maker
    always_comb begin
        next_s = s;
        // synchronisers: first flop feeds only the second
        next_s.done_s1 = l.done_tgl;
        next_s.done_s2 = s.done_s1;
        next_s.done_d = s.done_s2;
        next_s.ackp_s1 = l.acknowledge_detected_flag_tgl;
        next_s.ackp_s2 = s.ackp_s1;
        next_s.ackp_d = s.ackp_s2;
        next_s.sck_s1 = sclk_i;
        next_s.sck_s2 = s.sck_s1;
        next_s.sda_s1 = line_raw;
        next_s.sda_s2 = s.sda_s1;
        next_s.sda_d = s.sda_s2;

        // output latch written by triggers, never mid-transfer
        if (!s.st.transfer_busy) begin
            if (trig.release_trigger) begin
                next_s.so_latch = 1'b1;
            end else if (trig.command_trigger) begin
                next_s.so_latch = 1'b0;
            end
        end

        // acknowledge request held until the next start
        if (trig.acknowledge_trigger) begin
            next_s.ack_req = 1'b1;
        end

        // bus line edges while the clock sits high
        if (bus_mode && s.sck_s2) begin
            if (s.sda_s2 && !s.sda_d) begin
                next_s.st.release_detected = 1'b1;
                next_s.st.command_detected = 1'b0;
            end else if (!s.sda_s2 && s.sda_d) begin
                next_s.st.command_detected = 1'b1;
            end
        end

        // writes are ignored while a byte is moving
        if (trig.write && !s.st.transfer_busy) begin
            // stored in shift order, so reverse for lsb-first
            next_s.data = cfg.lsb_first ? csp_rev(wr_data) : wr_data;
            next_s.so_latch = cfg.lsb_first ? wr_data[0] : wr_data[7];
            if (can_start) begin
                next_s.st.transfer_busy = 1'b1;
                next_s.ack_req = 1'b0;
                // a busy slave holds the line low: wait for ready
                if (bus_mode && !s.sda_s2) begin
                    next_s.pending = 1'b1;
                end else begin
                    next_s.start_tgl = !s.start_tgl;
                end
            end
        end else if (s.pending && s.sda_s2) begin
            next_s.pending = 1'b0;
            next_s.start_tgl = !s.start_tgl;
        end

        // internal clock: half periods counted on the system clock
        next_s.sclk_oe = cfg.internal_clock && cfg.mode != CSP_HALT;
        if (s.st.transfer_busy && !s.pending && cfg.internal_clock &&
                s.gen_edges < gen_total) begin
            if (s.div_cnt == 4'(SCLK_HALF - 1)) begin
                next_s.div_cnt = 4'h0;
                next_s.gen_clk = !s.gen_clk;
                next_s.gen_edges = s.gen_edges + 5'h01;
            end else begin
                next_s.div_cnt = s.div_cnt + 4'h1;
            end
        end else if (!s.st.transfer_busy) begin
            next_s.gen_clk = 1'b1; // idle high
            next_s.gen_edges = 5'h00;
            next_s.div_cnt = 4'h0;
        end
        // port latch gates the clock, allowing static control
        next_s.sclk_o = s.gen_clk && clock_pin_port_latch;

        // end of transfer: the link has stopped, its register is stable
        if (done_ev) begin
            next_s.st.transfer_busy = 1'b0;
            next_s.data = l.shreg;
            next_s.so_latch = g.out_q;
            next_s.st.release_detected = 1'b0;
            next_s.st.command_detected = 1'b0;
            if (s.st.release_detected && s.st.command_detected) begin
                next_s.st.byte_kind = CSP_KIND_ADDRESS;
            end else if (s.st.command_detected) begin
                next_s.st.byte_kind = CSP_KIND_COMMAND;
            end else begin
                next_s.st.byte_kind = CSP_KIND_DATA;
            end
        end

        // interrupt flag: a new event beats a clear in the same cycle
        if (trig.irq_clear) begin
            next_s.st.serial_interrupt_flag = 1'b0;
        end
        if (done_ev) begin
            // wake-up is read live so software may flip it any time
            if (!(bus_mode && cfg.wake_up_select)) begin
                next_s.st.serial_interrupt_flag = 1'b1;
            end else if (s.st.release_detected && s.st.command_detected &&
                    addr_match) begin
                next_s.st.serial_interrupt_flag = 1'b1;
            end
        end

        // acknowledge seen on the line, set wins over clear
        if (trig.acknowledge_detected_flag_clear) begin
            next_s.st.acknowledge_detected_flag = 1'b0;
        end
        if (s.ackp_s2 ^ s.ackp_d) begin
            next_s.st.acknowledge_detected_flag = 1'b1;
        end

        next_s.st.read_data = cfg.lsb_first ? csp_rev(next_s.data) :
            next_s.data;

        if (srst) begin
            next_s = CSP_SYS_RST;
        end
    end

    // system state register
    always_ff @(posedge clk_sys) begin
        s <= next_s;
    end

    // ---------------- link clock domain ----------------

    // rising edge: sample line, count bits, report completion
    always_comb begin
        next_l = l;
        next_l.rst1 = srst;
        next_l.rst2 = l.rst1;
        if (l.rst2) begin
            next_l.seen = 1'b0;
            next_l.cnt = 4'h0;
            next_l.shreg = 8'h00;
            next_l.done_tgl = 1'b0;
            next_l.acknowledge_detected_flag_tgl = 1'b0;
        end else if (s.start_tgl != l.seen) begin
            // start toggle and data are held still until done comes back
            next_l.seen = s.start_tgl;
            next_l.cnt = 4'h1;
            next_l.shreg = {s.data[6:0], line_raw};
        end else if (l.cnt != 4'h0 && l.cnt < CSP_BITS) begin
            next_l.shreg = {l.shreg[6:0], line_raw};
            next_l.cnt = l.cnt + 4'h1;
            if (l.cnt == CSP_BITS - 4'h1 && !bus_mode) begin
                next_l.done_tgl = !l.done_tgl;
            end
        end else if (l.cnt == CSP_BITS) begin
            // ninth rising edge: acknowledge slot
            next_l.cnt = CSP_BUS_CLOCKS;
            if (!line_raw) begin
                next_l.acknowledge_detected_flag_tgl = !l.acknowledge_detected_flag_tgl;
            end
            if (bus_mode) begin
                next_l.done_tgl = !l.done_tgl;
            end
        end
    end

    // rising edge register
    always_ff @(posedge sclk_link) begin
        l <= next_l;
    end

    // falling edge: next bit out, acknowledge drive
    always_comb begin
        next_g = g;
        if (s.start_tgl != l.seen) begin
            // first fall of a byte: physical msb goes out
            next_g.out_q = s.data[7];
        end else if (bus_mode && l.cnt == CSP_BITS) begin
            // ninth clock: data bit let go for the acknowledge slot
            next_g.out_q = 1'b1;
        end else begin
            next_g.out_q = l.shreg[7];
        end
        // low from the ninth fall until the ninth rise after a received byte
        next_g.ack_drv = bus_mode && l.cnt == CSP_BITS &&
            (cfg.auto_acknowledge_enable || s.ack_req);
        if (l.rst2) begin
            next_g.out_q = 1'b1;
            next_g.ack_drv = 1'b0;
        end
    end

    // falling edge register
    always_ff @(negedge sclk_link) begin
        g <= next_g;
    end

    // ---------------- pins ----------------

    // the falling-edge flop owns the bit only once shifting began;
    // this mux picks between the two domains' output bits, both inputs are flops
    // only once this start was seen at a rising edge; counts left from
    // the previous byte must not hand the pin to a stale bit
    assign link_on = s.st.transfer_busy && !s.pending &&
        l.seen == s.start_tgl && l.cnt != 4'h0 && l.cnt <= CSP_BITS;
    always_comb begin
        dval = link_on ? g.out_q : s.so_latch;
        // wake-up keeps the pull-down off while listening
        if (bus_mode && cfg.wake_up_select) begin
            dval = 1'b1;
        end
        // acknowledge ends at the ninth rise, the clock then idles high
        pull_low = !dval || (g.ack_drv && l.cnt == CSP_BITS) ||
            (bus_mode && cfg.busy_output_enable &&
            !s.st.transfer_busy);
    end

    // pin drivers per mode; halt leaves both data pins as inputs
    always_comb begin
        pa_o = 1'b0;
        pa_oe = 1'b0;
        pb_o = 1'b0;
        pb_oe = 1'b0;
        unique case (cfg.mode)
            CSP_HALT: begin
                pa_oe = 1'b0;
            end
            CSP_THREE_WIRE: begin
                pa_o = dval;
                pa_oe = 1'b1;
            end
            CSP_TWO_WIRE, CSP_SERIAL_BUS: begin
                // open drain: only ever pull low
                if (cfg.data_on_pin_b) begin
                    pb_oe = pull_low;
                end else begin
                    pa_oe = pull_low;
                end
            end
        endcase
        if (srst) begin
            pa_oe = 1'b0;
            pb_oe = 1'b0;
        end
    end

    assign sclk_o = s.sclk_o;
    assign sclk_oe = s.sclk_oe;
    assign stat = s.st;

    // ---------------- checks ----------------

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    AST_HALT_NO_SHIFT: assert property (
        cfg.mode == CSP_HALT && trig.write && !s.st.transfer_busy |=>
        !s.st.transfer_busy && s.data == ($past(cfg.lsb_first) ?
        csp_rev($past(wr_data)) : $past(wr_data)))
        else $error("halt mode write started a transfer");

    AST_RESET_INPUTS: assert property (
        $past(srst) |-> !s.st.transfer_busy && !s.sclk_oe &&
        s.so_latch && !s.st.serial_interrupt_flag)
        else $error("reset did not return the channel to halt");

    AST_CLOCK_INPUT: assert property (
        !$past(cfg.internal_clock) |-> !sclk_oe)
        else $error("clock pin driven while external clock chosen");

    AST_CLOCK_LATCH: assert property (
        !$past(clock_pin_port_latch) |-> !sclk_o)
        else $error("clock pin high while port latch low");

    AST_ORDER: assert property (
        trig.write && !s.st.transfer_busy && cfg.mode == CSP_HALT &&
        $stable(cfg.lsb_first) ##1 $stable(cfg.lsb_first) |->
        s.st.read_data == $past(wr_data))
        else $error("read back differs from written byte");

    AST_START: assert property (
        trig.write && !s.st.transfer_busy && can_start && !bus_mode |=>
        s.st.transfer_busy && s.start_tgl != $past(s.start_tgl))
        else $error("write with channel ready did not start");

    AST_NO_LATE_ENABLE: assert property (
        !s.st.transfer_busy && !trig.write && !s.pending |=>
        s.start_tgl == $past(s.start_tgl))
        else $error("transfer started without a write");

    AST_DONE_IRQ: assert property (
        done_ev && !bus_mode |=> !s.st.transfer_busy ##0
        s.st.serial_interrupt_flag)
        else $error("completion did not raise interrupt");

    AST_WAKE: assert property (
        done_ev && bus_mode && cfg.wake_up_select && !addr_match &&
        !s.st.serial_interrupt_flag |=> !s.st.serial_interrupt_flag)
        else $error("wake-up interrupt without address match");

    AST_OPEN_DRAIN: assert property (
        od_mode |-> !pa_o && !pb_o)
        else $error("open-drain data pin driven high");

endmodule

// ==== csp_pkg.sv ====
package csp_pkg;

    // channel operating modes
    typedef enum logic [1:0] {CSP_HALT, CSP_THREE_WIRE, CSP_TWO_WIRE,
        CSP_SERIAL_BUS} csp_mode_t;

    // class of a byte moved in serial bus mode
    typedef enum logic [1:0] {CSP_KIND_DATA, CSP_KIND_COMMAND,
        CSP_KIND_ADDRESS} csp_kind_t;

    // configuration levels held by the cpu (serial_mode_register and friends)
    typedef struct packed {
        csp_mode_t mode;              // channel mode
        logic lsb_first;              // first-bit select
        logic internal_clock;         // clock pin in output mode
        logic data_on_pin_b;          // bus data on pin b instead of pin a
        logic serial_channel_enable;  // transfers allowed
        logic wake_up_select;         // address-match interrupt only
        logic auto_acknowledge_enable;
        logic busy_output_enable;
        logic [7:0] slave_address_register;
    } csp_cfg_t;

    // one-cycle strobes from the cpu
    typedef struct packed {
        logic write;                  // shift_register write
        logic release_trigger;        // output latch to 1
        logic command_trigger;        // output latch to 0
        logic acknowledge_trigger;    // request one acknowledge clock
        logic irq_clear;              // clear serial_interrupt_flag
        logic acknowledge_detected_flag_clear;             // clear acknowledge_detected_flag
    } csp_trig_t;

    // status shown to the cpu
    typedef struct packed {
        logic [7:0] read_data;
        logic serial_interrupt_flag;
        logic acknowledge_detected_flag;
        logic release_detected;
        logic command_detected;
        logic transfer_busy;
        csp_kind_t byte_kind;
    } csp_stat_t;

    // system-clock side state
    typedef struct packed {
        csp_stat_t st;
        logic [7:0] data;             // shift_register, physical order
        logic so_latch;               // idle serial output level
        logic pending;                // start waits for ready line
        logic start_tgl;
        logic ack_req;
        logic done_s1, done_s2, done_d;
        logic ackp_s1, ackp_s2, ackp_d;
        logic sck_s1, sck_s2;
        logic sda_s1, sda_s2, sda_d;
        logic gen_clk;                // internally made serial clock
        logic [4:0] gen_edges;
        logic [3:0] div_cnt;
        logic sclk_o, sclk_oe;
    } csp_sys_t;

    // link-clock rising-edge state
    typedef struct packed {
        logic rst1, rst2;
        logic seen;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic done_tgl;
        logic acknowledge_detected_flag_tgl;
    } csp_lnk_t;

    // link-clock falling-edge state
    typedef struct packed {
        logic out_q;
        logic ack_drv;
    } csp_neg_t;

    localparam logic [3:0] CSP_BITS = 4'h8;
    localparam logic [3:0] CSP_BUS_CLOCKS = 4'h9;
    localparam int CSP_CLK_NS = 100;
    localparam int CSP_SCLK_HALF_NS = 500;
    localparam int CSP_SCLK_HALF_CYC =
        (CSP_SCLK_HALF_NS + CSP_CLK_NS - 1) / CSP_CLK_NS;
    localparam logic CSP_CLOCK_LATCH_RST = 1'b1;

    localparam csp_sys_t CSP_SYS_RST = '{
        st: '0, data: 8'h00, so_latch: 1'b1, pending: 1'b0,
        start_tgl: 1'b0, ack_req: 1'b0,
        done_s1: 1'b0, done_s2: 1'b0, done_d: 1'b0,
        ackp_s1: 1'b0, ackp_s2: 1'b0, ackp_d: 1'b0,
        sck_s1: 1'b1, sck_s2: 1'b1,
        sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1,
        gen_clk: 1'b1, gen_edges: 5'h00, div_cnt: 4'h0,
        sclk_o: 1'b1, sclk_oe: 1'b0};

    // bit reversal used for lsb-first access
    function automatic logic [7:0] csp_rev(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7 - i];
        end
        return r;
    endfunction

endpackage

// ==== csp_far_end.sv ====
`timescale 1ns/1ps
// far end of the link: clocks bits in and out, idle high between frames
module csp_far_end (
    output logic sclk,       // serial clock from far end, idle high
    output logic da,         // far end pull on line a (open drain)
    output logic db,         // far end push on line b
    input wire logic a_line  // resolved level of line a
);
    // clock stands high and lines are released until a frame is asked for
    initial begin
        sclk = 1'b1;
        da = 1'b1;
        db = 1'b1;
    end

    // one frame of n bits, msb first; bits change after fall, sampled on rise
    task automatic frame(input int n, input logic [8:0] tx,
            input logic on_b, output logic [8:0] rx);
        rx = 9'h000;
        for (int i = n - 1; i >= 0; i--) begin
            sclk = 1'b0;
            if (on_b) begin
                db = tx[i];
            end else begin
                da = tx[i];
            end
            #6;
            sclk = 1'b1;
            rx = {rx[7:0], a_line};
            #6;
        end
        // released line a goes back to the pull-up level
        da = 1'b1;
        // pushed line b no longer holds its last bit once the frame ends
        db = ~db;
    endtask

    // release edge then command edge on line a, clock held high
    task automatic marks();
        da = 1'b0;
        #500;
        da = 1'b1;
        #500;
        da = 1'b0;
        #500;
    endtask
endmodule

// ==== csp_serial_port_test.sv ====
`timescale 1ns/1ps
module csp_serial_port_test;
    import csp_pkg::*;

    typedef struct packed {
        csp_mode_t mode;    // channel mode for the row
        logic lsb;          // first-bit select
        logic [7:0] wr;     // value written
        logic [7:0] ptx;    // far end sends this
        logic [7:0] line;   // far end should see this
        logic [7:0] rd;     // read_data after the row
    } csp_row_t;

    logic clk_sys = 1'b0;     // system clock
    logic srst = 1'b1;        // sync reset
    csp_cfg_t cfg = '0;       // configuration levels
    csp_trig_t trig = '0;     // cpu strobes
    logic [7:0] wr_data = 8'h00;
    logic port_latch = 1'b1;  // static clock pin level
    csp_stat_t stat;
    logic sclk_o, sclk_oe, pa_o, pa_oe, pb_o, pb_oe;
    logic p_sclk, p_da, p_db; // far end drives
    int errors = 0;
    int num_checks = 0;
    logic [8:0] rx;
    // resolved lines: pull-ups on both data lines, open drain wired together; clock from the port when it drives
    wire sclk_line = sclk_oe ? sclk_o : p_sclk;
    wire a_line = (pa_oe ? pa_o : 1'b1) & p_da;
    wire b_line = (pb_oe ? pb_o : 1'b1) & p_db;

    // halt rows store only; transfer rows exercise bit order and wiring
    csp_row_t rows [5] = '{
        '{CSP_HALT, 1'b0, 8'h3c, 8'h00, 8'h00, 8'h3c},
        '{CSP_HALT, 1'b1, 8'h96, 8'h00, 8'h00, 8'h96},
        '{CSP_THREE_WIRE, 1'b0, 8'ha5, 8'h3c, 8'ha5, 8'h3c},
        '{CSP_THREE_WIRE, 1'b1, 8'h01, 8'h12, 8'h80, 8'h48},
        '{CSP_TWO_WIRE, 1'b0, 8'hc3, 8'h5f, 8'h43, 8'h43}};
    logic [7:0] addrs [3] = '{8'h5a, 8'ha5, 8'ha5};
    logic wakes [3] = '{1'b1, 1'b1, 1'b0};
    logic irqs [3] = '{1'b1, 1'b0, 1'b1};

    csp_serial_port #(.SCLK_HALF(1)) csp_serial_port_i (
        .clk_sys(clk_sys), .srst(srst), .sclk_link(sclk_line),
        .cfg(cfg), .trig(trig), .wr_data(wr_data),
        .clock_pin_port_latch(port_latch), .stat(stat),
        .sclk_i(sclk_line), .sclk_o(sclk_o), .sclk_oe(sclk_oe),
        .pa_i(a_line), .pa_o(pa_o), .pa_oe(pa_oe),
        .pb_i(b_line), .pb_o(pb_o), .pb_oe(pb_oe));

    csp_far_end csp_far_end_i (
        .sclk(p_sclk), .da(p_da), .db(p_db), .a_line(a_line));

    // free-running system clock
    always #50 clk_sys = ~clk_sys;

    // verdict and end of run
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // single comparison point
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // one-cycle strobe, inputs moved on the edge
    task automatic pulse(input csp_trig_t t, input logic [7:0] d);
        @(posedge clk_sys);
        trig <= t;
        wr_data <= d;
        @(posedge clk_sys);
        trig <= '0;
        #1;
    endtask

    // bounded wait on the busy flag
    task automatic wait_busy(input logic lvl);
        int k;
        for (k = 0; k < 400; k++) begin
            @(posedge clk_sys);
            #1;
            if (stat.transfer_busy === lvl) break;
        end
        if (k == 400) begin
            errors++;
            close_out();
        end
    endtask

    // link domain needs its clock moving while reset is held
    task automatic do_reset();
        @(posedge clk_sys);
        srst <= 1'b1;
        cfg <= '0;
        fork
            csp_far_end_i.frame(4, 9'h1ff, 1'b0, rx);
            repeat (12) @(posedge clk_sys);
        join
        srst <= 1'b0;
        // more link edges so the link reset synchroniser clears
        csp_far_end_i.frame(4, 9'h1ff, 1'b0, rx);
        tick(2);
    endtask

    initial begin
        do_reset();
        foreach (rows[i]) begin
            @(posedge clk_sys);
            cfg.mode <= rows[i].mode;
            cfg.lsb_first <= rows[i].lsb;
            cfg.serial_channel_enable <= 1'b1;
            tick(3);
            pulse('{write: 1'b1, default: 1'b0}, rows[i].wr);
            if (rows[i].mode == CSP_HALT) begin
                tick(3);
                check(stat.transfer_busy, 16'h0);
            end else begin
                wait_busy(1'b1);
                csp_far_end_i.frame(8, {1'b0, rows[i].ptx},
                    rows[i].mode == CSP_THREE_WIRE, rx);
                wait_busy(1'b0);
                check(rx[7:0], rows[i].line);
                check(stat.serial_interrupt_flag, 16'h1);
            end
            check(stat.read_data, rows[i].rd);
            pulse('{irq_clear: 1'b1, default: 1'b0}, 8'h00);
        end
        // internal clock: pin follows the port latch, else plain input
        @(posedge clk_sys);
        cfg.internal_clock <= 1'b1;
        port_latch <= 1'b0;
        tick(4);
        check({sclk_oe, sclk_o}, 16'h2);
        @(posedge clk_sys);
        port_latch <= 1'b1;
        cfg.internal_clock <= 1'b0;
        tick(4);
        check(sclk_oe, 16'h0);
        // idle output latch moved by the triggers, two-wire pin a
        pulse('{command_trigger: 1'b1, default: 1'b0}, 8'h00);
        tick(1);
        check({pa_oe, a_line}, 16'h2);
        pulse('{release_trigger: 1'b1, default: 1'b0}, 8'h00);
        tick(1);
        check({pa_oe, a_line}, 16'h1);
        // second reset in mid-run
        do_reset();
        check(stat, 16'h0);
        check({pa_oe, pb_oe, sclk_oe}, 16'h0);
        // bus mode: address frames with and without wake-up
        @(posedge clk_sys);
        cfg.mode <= CSP_SERIAL_BUS;
        cfg.serial_channel_enable <= 1'b1;
        cfg.slave_address_register <= 8'h5a;
        for (int k = 0; k < 3; k++) begin
            @(posedge clk_sys);
            cfg.wake_up_select <= wakes[k];
            cfg.auto_acknowledge_enable <= (k == 2);
            tick(3);
            pulse('{write: 1'b1, default: 1'b0}, 8'hff);
            wait_busy(1'b1);
            csp_far_end_i.marks();
            csp_far_end_i.frame(9, {addrs[k], 1'b1}, 1'b0, rx);
            wait_busy(1'b0);
            check(stat.serial_interrupt_flag, irqs[k]);
            check(stat.byte_kind, CSP_KIND_ADDRESS);
            check(stat.read_data, addrs[k]);
            check(rx[0], k != 2);
            check(stat.acknowledge_detected_flag, k == 2);
            pulse('{irq_clear: 1'b1, acknowledge_detected_flag_clear: 1'b1, default: 1'b0},
                8'h00);
        end
        // busy indication pulls the idle bus line low
        @(posedge clk_sys);
        cfg.busy_output_enable <= 1'b1;
        tick(2);
        check({pa_oe, a_line}, 16'h2);
        close_out();
    end
endmodule
